/* File: rtl/ect_pkg.sv */
// constants, types and config carrier for exposure timing
package ect_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int DUR_W = 24;
  localparam int NS_W = 32;
  localparam int NUM_CH = 3;
  // setting unit is 0.01 us
  localparam int UNIT_NS = 10;
  localparam logic [DUR_W-1:0] EXP_MIN = 24'h00000b;
  localparam logic [DUR_W-1:0] EXP_RST = 24'h000064;
  localparam logic [DUR_W-1:0] PERIOD_RST = 24'h0003e8;
  // sensor offsets, ns
  localparam int OFFSET_COLOUR_NS = 3110;
  localparam int OFFSET_MONO_NS = 1540;
  // pulse length corrections, ns subtracted
  localparam int CORR_INT_NS = 0;
  localparam int CORR_TTL_HI_NS = 420;
  localparam int CORR_TTL_LO_NS = 60;
  // trigger edge to exposure start, ns
  localparam int TRIG_DELAY_NS = 200;
  localparam int TRIG_DELAY_CYC = (TRIG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CH_NONE = 2'h3;

  typedef enum logic [1:0] {BEH_OFF, BEH_TIMED, BEH_PULSE_LENGTH} ect_beh_t;
  typedef enum logic [1:0] {SRC_INTERNAL, SRC_TTL_HIGH, SRC_TTL_LOW, SRC_OPTO} ect_src_t;

  typedef struct packed {
    ect_beh_t exposure_behaviour_select;
    logic channel_duration_setting;
    logic [1:0] colour_channel_pick;
    logic rate_first;
    logic external_trigger_enable;
    ect_src_t trig_source;
    logic mono_model;
  } ect_cfg_t;
endpackage : ect_pkg

/* File: rtl/ect_exposure_timing.sv */
// exposure timing control for a line scan sensor
// Notes on behaviour
// - off selection: free-running, no duration control
// - preset mode: trigger starts programmed-length exposure
// - pulse mode: exposure follows trigger pulse length
// - add fixed sensor offset per model
// - shared duration default, one value all channels
// - per-channel values, picker selects written channel
// - stagger channel starts so all end together
// - non-preset selection forces shared duration
// - duration priority rejects too fast line rates
// - rate priority clips exposure to derived maximum
// - exposure at least 0.11us, 0.01us steps
// - ttl high: 0.53us pulses, minus 0.42us
// - ttl low: 0.17us pulses, minus 0.06us
// - fixed delay from external trigger edge
`timescale 1ns/100ps
`default_nettype none
module ect_exposure_timing (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // configuration levels
  input wire ect_pkg::ect_cfg_t cfg,
  // exposure duration write, 0.01 us units
  input wire logic exp_wr,
  input wire logic [ect_pkg::DUR_W-1:0] exposure_duration_setting,
  // line period write, 0.01 us units
  input wire logic rate_wr,
  input wire logic [ect_pkg::DUR_W-1:0] scan_line_frequency,
  // trigger pin, raw level
  input wire logic trig_pin,
  // exposure timing
  output logic exposure_active,
  output logic [ect_pkg::NUM_CH-1:0] channel_exposure,
  output logic line_start,
  // status
  output logic [ect_pkg::DUR_W-1:0] exp_readback,
  output logic [ect_pkg::DUR_W-1:0] period_readback,
  output logic exp_refused,
  output logic rate_refused,
  output logic exp_clipped
);
  import ect_pkg::*;

  localparam int DLY_C = TRIG_DELAY_CYC;
  localparam logic [NS_W-1:0] STEP_NS = NS_W'(CLK_PERIOD_NS);

  typedef enum logic [1:0] {ST_IDLE, ST_TIMED, ST_PULSE, ST_TAIL} ect_state_t;

  function automatic logic [NS_W-1:0] to_ns(input logic [DUR_W-1:0] u);
    return NS_W'(u) * NS_W'(UNIT_NS);
  endfunction : to_ns

  function automatic logic [DUR_W-1:0] max2(input logic [DUR_W-1:0] a,
                                            input logic [DUR_W-1:0] b);
    return (a > b) ? a : b;
  endfunction : max2

  // reset release
  logic [1:0] rs_r;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rs_r <= 2'h0;
    else rs_r <= {rs_r[0], 1'b1};
  end
  assign rst_n = rs_r[1];

  ect_state_t state_r;
  logic [DUR_W-1:0] exp_r [NUM_CH];
  logic [DUR_W-1:0] period_r;
  logic [NS_W-1:0] elapsed_r, line_ns_r, lat_max_r, lat_end_r, tail_ns_r;
  logic [NS_W-1:0] lat_ns_r [NUM_CH];
  logic [DLY_C-1:0] dly_r;
  logic trig_prev_r;

  logic mode_off, mode_timed, mode_pulse, eff_ind, ext;
  logic [1:0] pick;
  assign mode_off = cfg.exposure_behaviour_select == BEH_OFF;
  assign mode_timed = cfg.exposure_behaviour_select == BEH_TIMED;
  assign mode_pulse = cfg.exposure_behaviour_select == BEH_PULSE_LENGTH;
  assign ext = cfg.external_trigger_enable;
  assign pick = cfg.colour_channel_pick;
  assign eff_ind = cfg.channel_duration_setting & mode_timed & ~cfg.mono_model;

  // offsets and corrections
  logic [NS_W-1:0] off_ns, corr_ns, period_ns;
  logic [DUR_W-1:0] off_u;
  assign off_ns = cfg.mono_model ? NS_W'(OFFSET_MONO_NS) : NS_W'(OFFSET_COLOUR_NS);
  assign off_u = DUR_W'(off_ns / NS_W'(UNIT_NS));
  assign period_ns = to_ns(period_r);
  always_comb begin
    corr_ns = NS_W'(CORR_INT_NS);
    if (ext && cfg.trig_source == SRC_TTL_HIGH) corr_ns = NS_W'(CORR_TTL_HI_NS);
    if (ext && cfg.trig_source == SRC_TTL_LOW) corr_ns = NS_W'(CORR_TTL_LO_NS);
  end

  // per-channel effective durations
  logic [DUR_W-1:0] eff_u [NUM_CH];
  logic [NS_W-1:0] eff_ns [NUM_CH];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_eff
      assign eff_u[g] = eff_ind ? exp_r[g] : exp_r[0];
      assign eff_ns[g] = to_ns(eff_u[g]);
    end
  endgenerate
  logic [DUR_W-1:0] max_eff_u, max_all_u;
  assign max_eff_u = max2(max2(eff_u[0], eff_u[1]), eff_u[2]);
  assign max_all_u = max2(max2(exp_r[0], exp_r[1]), exp_r[2]);

  // write acceptance
  logic [DUR_W:0] need_u, floor_u, exp_top_u;
  logic rate_ok, exp_ok, pick_ok;
  logic [DUR_W-1:0] clip_u;
  assign need_u = {1'b0, max_all_u} + {1'b0, off_u};
  assign floor_u = {1'b0, EXP_MIN} + {1'b0, off_u};
  assign exp_top_u = {1'b0, exposure_duration_setting} + {1'b0, off_u};
  assign rate_ok = rate_wr & (cfg.rate_first ? ({1'b0, scan_line_frequency} >= floor_u)
                                             : ({1'b0, scan_line_frequency} >= need_u));
  assign clip_u = scan_line_frequency - off_u;
  assign pick_ok = ~eff_ind | (pick != CH_NONE);
  assign exp_ok = exp_wr & ~rate_wr & pick_ok & (exposure_duration_setting >= EXP_MIN) &
                  (exp_top_u <= {1'b0, period_r});

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) period_r <= PERIOD_RST;
    else if (rate_ok) period_r <= scan_line_frequency;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NUM_CH; c++) exp_r[c] <= EXP_RST;
    end else if (rate_ok && cfg.rate_first) begin
      for (int c = 0; c < NUM_CH; c++) if (exp_r[c] > clip_u) exp_r[c] <= clip_u;
    end else if (exp_ok && eff_ind) begin
      exp_r[pick] <= exposure_duration_setting;
    end else if (exp_ok) begin
      for (int c = 0; c < NUM_CH; c++) exp_r[c] <= exposure_duration_setting;
    end
  end

  // status flags
  logic any_clip;
  assign any_clip = rate_ok & cfg.rate_first & (max_all_u > clip_u);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_refused <= 1'b0;
      rate_refused <= 1'b0;
      exp_clipped <= 1'b0;
      exp_readback <= EXP_RST;
      period_readback <= PERIOD_RST;
    end else begin
      exp_refused <= exp_wr & ~exp_ok;
      rate_refused <= rate_wr & ~rate_ok;
      exp_clipped <= any_clip;
      exp_readback <= exp_r[(eff_ind && pick != CH_NONE) ? pick : 2'h0];
      period_readback <= period_r;
    end
  end

  // internal line timer in ns
  logic int_line, int_lvl;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) line_ns_r <= '0;
    else if (line_ns_r + STEP_NS >= period_ns) line_ns_r <= '0;
    else line_ns_r <= line_ns_r + STEP_NS;
  end
  assign int_line = line_ns_r == '0;
  assign int_lvl = line_ns_r < eff_ns[0];

  // trigger conditioning and delay
  logic trig_norm, trig_d, trig_rise;
  assign trig_norm = (cfg.trig_source == SRC_TTL_LOW) ? ~trig_pin : trig_pin;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) dly_r <= '0;
    else dly_r <= {dly_r[DLY_C-2:0], trig_norm};
  end
  assign trig_d = ext ? dly_r[DLY_C-1] : int_lvl;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) trig_prev_r <= 1'b0;
    else trig_prev_r <= trig_d;
  end
  assign trig_rise = trig_d & ~trig_prev_r;

  // exposure sequencer
  logic start_timed, start_pulse, start_tail, timed_done, tail_done;
  assign start_timed = (state_r == ST_IDLE) & mode_timed & trig_rise;
  assign start_pulse = (state_r == ST_IDLE) & mode_pulse & trig_rise;
  assign start_tail = (state_r == ST_PULSE) & ~trig_d;
  assign timed_done = elapsed_r + STEP_NS >= lat_end_r;
  assign tail_done = elapsed_r + STEP_NS >= tail_ns_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state_r <= ST_IDLE;
    else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_timed) state_r <= ST_TIMED;
          else if (start_pulse) state_r <= ST_PULSE;
        end
        ST_TIMED: if (timed_done) state_r <= ST_IDLE;
        ST_PULSE: if (start_tail) state_r <= ST_TAIL;
        ST_TAIL: if (tail_done) state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) elapsed_r <= '0;
    else if (start_timed || start_tail) elapsed_r <= '0;
    else elapsed_r <= elapsed_r + STEP_NS;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_max_r <= '0;
      lat_end_r <= '0;
      tail_ns_r <= '0;
      for (int c = 0; c < NUM_CH; c++) lat_ns_r[c] <= '0;
    end else begin
      if (start_timed) begin
        lat_max_r <= to_ns(max_eff_u);
        lat_end_r <= to_ns(max_eff_u) + off_ns;
        for (int c = 0; c < NUM_CH; c++) lat_ns_r[c] <= eff_ns[c];
      end
      if (start_tail) tail_ns_r <= off_ns - corr_ns;
    end
  end

  // channel windows
  logic [NUM_CH-1:0] ch_nxt;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign ch_nxt[g] = (state_r == ST_TIMED) ? (elapsed_r >= lat_max_r - lat_ns_r[g])
                                              : ((state_r != ST_IDLE) | mode_off);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_exposure <= '0;
      exposure_active <= 1'b0;
      line_start <= 1'b0;
    end else begin
      channel_exposure <= ch_nxt;
      exposure_active <= (state_r != ST_IDLE) | mode_off;
      line_start <= mode_off ? (ext ? trig_rise : int_line) : (start_timed | start_pulse);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_off_free_run: assert property (mode_off && $past(mode_off) && $past(rst_n) |->
                                     exposure_active)
    else $error("free-running output not held");
  chk_timed_start: assert property (start_timed |=> state_r == ST_TIMED && elapsed_r == '0)
    else $error("timed exposure did not start");
  chk_pulse_follow: assert property (state_r == ST_PULSE && trig_d |=> state_r == ST_PULSE)
    else $error("pulse exposure ended early");
  chk_tail_length: assert property (start_tail |=> tail_ns_r == $past(off_ns) - $past(corr_ns))
    else $error("tail length wrong");
  chk_timed_end: assert property (state_r == ST_TIMED && timed_done |=> state_r == ST_IDLE)
    else $error("timed exposure overran");
  chk_shared_equal: assert property (!eff_ind && state_r == ST_TIMED |->
                                     ch_nxt == '0 || ch_nxt == '1)
    else $error("shared channels differ");
  chk_pick_write: assert property (exp_ok && eff_ind |=> exp_r[$past(pick)] ==
                                   $past(exposure_duration_setting))
    else $error("picked channel not written");
  chk_common_end: assert property ($fell(exposure_active) && !mode_off |->
                                   $past(channel_exposure) == '1)
    else $error("channels did not end together");
  chk_rate_cap: assert property (rate_ok && !cfg.rate_first |=>
                                 {1'b0, period_r} >= $past(need_u))
    else $error("line rate above exposure cap");
  chk_rate_clip: assert property (rate_ok && cfg.rate_first |=>
                                  exp_r[0] <= $past(clip_u) && exp_r[2] <= $past(clip_u))
    else $error("exposure not clipped");
  chk_min_refuse: assert property (exp_wr && exposure_duration_setting < EXP_MIN |=>
                                   exp_refused)
    else $error("short exposure accepted");
  chk_trig_delay: assert property ($rose(trig_norm) |-> ##DLY_C dly_r[DLY_C-1])
    else $error("trigger delay wrong");
  chk_pulse_start: assert property (start_pulse |=> state_r == ST_PULSE)
    else $error("pulse exposure did not start");
  chk_tail_end: assert property (state_r == ST_TAIL && tail_done |=>
                                 state_r == ST_IDLE)
    else $error("pulse tail overran");
  chk_shared_forced: assert property (!mode_timed |-> eff_u[1] == exp_r[0] &&
                                      eff_u[2] == exp_r[0])
    else $error("shared duration not forced");
  chk_rate_refuse: assert property (rate_wr && !cfg.rate_first &&
                                    {1'b0, scan_line_frequency} < need_u |=>
                                    rate_refused && period_r == $past(period_r))
    else $error("too fast line rate taken");
  chk_clip_value: assert property (rate_ok && cfg.rate_first &&
                                   max_all_u > clip_u |=> exp_clipped && max_all_u == $past(clip_u))
    else $error("clipped exposure wrong");
  chk_time_step: assert property (state_r != ST_IDLE && !start_tail |=>
                                  elapsed_r == $past(elapsed_r) + STEP_NS)
    else $error("exposure timebase skipped");
  chk_ext_latency: assert property ((start_timed || start_pulse) && ext |->
                                    $past(trig_norm, DLY_C))
    else $error("exposure started before delay");
endmodule : ect_exposure_timing
`default_nettype wire

/* File: testbench/ect_trig_source.sv */
// trigger source model driving the camera trigger pin
`timescale 1ns/100ps
`default_nettype none
module ect_trig_source (
  // clock
  input wire logic sys_clk,
  // electrical kind of the trigger input
  input wire ect_pkg::ect_src_t src,
  // trigger pin
  output logic trig_pin
);
  import ect_pkg::*;
  logic act = 1'b0;
  // idle level follows the pin polarity
  assign trig_pin = act ^ (src == SRC_TTL_LOW);
  task automatic pulse(input int w);
    int n;
    n = (src == SRC_TTL_HIGH) ? 67 : (src == SRC_TTL_LOW) ? 22 : 14;
    if (w > n) n = w;
    @(posedge sys_clk);
    #1;
    act = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    act = 1'b0;
  endtask : pulse
endmodule : ect_trig_source
`default_nettype wire

/* File: testbench/ect_exposure_timing_tb.sv */
// self-checking bench for exposure timing control
`timescale 1ns/100ps
`default_nettype none
module ect_exposure_timing_tb;
  import ect_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  ect_cfg_t cfg = '0;
  logic exp_wr = 1'b0;
  logic rate_wr = 1'b0;
  logic [DUR_W-1:0] exp_val = EXP_RST;
  logic [DUR_W-1:0] per_val = PERIOD_RST;
  wire logic trig_pin;
  logic act, ls, eref, rref, clip, seen_clip, mon_on = 1'b0;
  logic [NUM_CH-1:0] chan, first_ch;
  logic [DUR_W-1:0] exp_rb, per_rb, v, mx;
  logic [DUR_W-1:0] vals [3];
  int err_count = 0;
  int n_compared = 0;
  int q[$];
  int n, w;
  always #4 sys_clk = ~sys_clk;
  ect_exposure_timing ect_exposure_timing_i (.sys_clk(sys_clk), .nrst(nrst), .cfg(cfg),
    .exp_wr(exp_wr), .exposure_duration_setting(exp_val), .rate_wr(rate_wr),
    .scan_line_frequency(per_val), .trig_pin(trig_pin), .exposure_active(act),
    .channel_exposure(chan), .line_start(ls), .exp_readback(exp_rb),
    .period_readback(per_rb), .exp_refused(eref), .rate_refused(rref), .exp_clipped(clip));
  ect_trig_source ect_trig_source_i (.sys_clk(sys_clk), .src(cfg.trig_source),
    .trig_pin(trig_pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // one write of exposure (r=0) or line period (r=1)
  task automatic wr(input logic r, input logic [DUR_W-1:0] d, input logic bad);
    if (r) per_val = d;
    else exp_val = d;
    rate_wr = r;
    exp_wr = ~r;
    tick(1);
    rate_wr = 1'b0;
    exp_wr = 1'b0;
    seen_clip = clip;
    check(r ? rref : eref, bad);
    tick(1);
  endtask : wr
  function automatic int dur(input int d, input int off);
    return (d * 10 + off + 7) / 8;
  endfunction : dur
  task automatic wait_q;
    repeat (3000) if (q.size() != 0) @(negedge sys_clk);
    if (q.size() != 0) begin
      err_count++;
      print_verdict();
    end
    tick(2);
  endtask : wait_q
  task automatic trig(input int pw);
    int c;
    c = 0;
    fork
      ect_trig_source_i.pulse(pw);
      while (ls !== 1'b1 && c < 400) begin
        @(negedge sys_clk);
        c++;
      end
    join
    check(c > TRIG_DELAY_CYC && c < 400, 1);
    wait_q();
  endtask : trig
  // watcher: length of each exposure against the oldest note
  initial forever begin
    @(negedge sys_clk);
    if (mon_on && ls === 1'b1) begin
      // exposure and channels follow line start by one cycle
      @(negedge sys_clk);
      first_ch = chan;
      n = 0;
      while (act === 1'b1 && n < 5000) begin
        n++;
        @(negedge sys_clk);
      end
      if (q.size() == 0) check(n, 0);
      else check(n, q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'hdef503ff));
    tick(2);
    nrst = 1'b1;
    tick(3);
    check(exp_rb, EXP_RST);
    check(per_rb, PERIOD_RST);
    wr(0, EXP_MIN - 24'h1, 1);
    wr(0, EXP_MIN, 0);
    check(exp_rb, EXP_MIN);
    $display("test limits done");
    cfg.exposure_behaviour_select = BEH_OFF;
    tick(4);
    check(act, 1);
    $display("test free run done");
    cfg.exposure_behaviour_select = BEH_TIMED;
    cfg.external_trigger_enable = 1'b1;
    cfg.trig_source = SRC_TTL_HIGH;
    mon_on = 1'b1;
    for (int m = 0; m < 2; m++) begin
      cfg.mono_model = m[0];
      v = 24'h0b + 24'($urandom % 256);
      wr(0, v, 0);
      q.push_back(dur(int'(v), m ? OFFSET_MONO_NS : OFFSET_COLOUR_NS));
      trig(70);
    end
    $display("test timed done");
    cfg.mono_model = 1'b0;
    cfg.channel_duration_setting = 1'b1;
    mx = '0;
    for (int c = 0; c < 3; c++) begin
      cfg.colour_channel_pick = c[1:0];
      vals[c] = 24'h0b + 24'($urandom % 256);
      if (vals[c] > mx) mx = vals[c];
      wr(0, vals[c], 0);
      check(exp_rb, vals[c]);
    end
    cfg.colour_channel_pick = CH_NONE;
    wr(0, 24'h20, 1);
    q.push_back(dur(int'(mx), OFFSET_COLOUR_NS));
    trig(70);
    check(first_ch, {vals[2] == mx, vals[1] == mx, vals[0] == mx});
    $display("test per channel done");
    cfg.exposure_behaviour_select = BEH_PULSE_LENGTH;
    // colour model on high-active pin, then mono on low-active pin
    for (int s = 0; s < 2; s++) begin
      cfg.mono_model = s[0];
      cfg.trig_source = s ? SRC_TTL_LOW : SRC_TTL_HIGH;
      tick(4);
      wr(0, 24'h30, 0);
      w = 67 + int'($urandom % 80);
      q.push_back(w + ((s ? OFFSET_MONO_NS - CORR_TTL_LO_NS
                          : OFFSET_COLOUR_NS - CORR_TTL_HI_NS) + 7) / 8);
      trig(w);
    end
    $display("test pulse length done");
    mon_on = 1'b0;
    cfg.exposure_behaviour_select = BEH_TIMED;
    cfg.channel_duration_setting = 1'b0;
    wr(0, 24'h100, 0);
    wr(1, 24'h100 + 24'd153, 1);
    wr(1, 24'h100 + 24'd154, 0);
    check(per_rb, 24'h100 + 24'd154);
    cfg.rate_first = 1'b1;
    wr(1, 24'haa, 0);
    check(seen_clip, 1);
    tick(2);
    check(exp_rb, 24'h10);
    $display("test priority done");
    print_verdict();
  end
endmodule : ect_exposure_timing_tb
`default_nettype wire
